/* rtl/qdw_pkg.sv */
package qdw_pkg;
  // ----------------------------------------
  // Word layout
  // ----------------------------------------
  localparam int CH_N = 4;
  localparam int DATA_W = 12;
  localparam int PD_W = 2;
  localparam int WORD_W = 14;
  localparam int CH_W = 2;
  // ----------------------------------------
  // Address and control byte fields
  // ----------------------------------------
  localparam logic [4:0] ADDR_FIXED = 5'h13;
  localparam int ADDR_FIXED_LSB = 3;
  localparam int ADDR_PIN_LSB = 1;
  localparam int ADDR_RW_BIT = 0;
  localparam logic ADDR_RW_WRITE = 1'h0;
  localparam int CTRL_ZERO_LSB = 6;
  localparam int CTRL_LOAD_LSB = 4;
  localparam int CTRL_CHAN_LSB = 1;
  localparam int CTRL_BCAST_BIT = 2;
  localparam int CTRL_KIND_BIT = 0;
  localparam logic [1:0] LOAD_HOLD = 2'h0;
  localparam logic [1:0] LOAD_ONE = 2'h1;
  localparam logic [1:0] LOAD_ALL = 2'h2;
  localparam logic [1:0] LOAD_BCAST = 2'h3;
  localparam logic [7:0] HS_CODE = 8'h08;
  localparam int PD_LSB = 6;
  localparam int LO_DATA_LSB = 4;
  localparam int NIB_W = 4;
  localparam logic [3:0] ACK_IDX = 4'h8;
  // ----------------------------------------
  // Controller timing at 250 MHz core clock
  // ----------------------------------------
  localparam int CORE_PERIOD_NS = 4;
  localparam int FS_BIT_NS = 2500;
  localparam int HS_BIT_NS = 294;
  localparam int QTR_N = 4;
  localparam logic [7:0] FS_QTR_CYC = 8'((FS_BIT_NS / QTR_N + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS);
  localparam logic [7:0] HS_QTR_CYC = 8'((HS_BIT_NS / QTR_N + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS);
  // ----------------------------------------
  // Controller registers
  // ----------------------------------------
  localparam int AXI_AW = 4;
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_PD_LSB = 12;
  localparam int CMD_CHAN_LSB = 16;
  localparam int CMD_LOAD_LSB = 20;
  localparam int CMD_KIND_BIT = 24;
  localparam int CMD_HS_BIT = 25;
  localparam int CMD_PIN_LSB = 28;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [2:0] IDX_HS = 3'h0;
  localparam logic [2:0] IDX_ADDR = 3'h1;
  localparam logic [2:0] IDX_CTRL = 3'h2;
  localparam logic [2:0] IDX_LO = 3'h4;
  // ----------------------------------------
  // State machines
  // ----------------------------------------
  typedef enum logic [3:0] {D_IDLE, D_ADDR, D_CTRL, D_HI, D_LO, D_PD1, D_PD2, D_DONE, D_SKIP} qdw_dstate_type;
  typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} qdw_mstate_type;
endpackage

/* rtl/qdw_if.sv */
`timescale 1ns/1ns
interface qdw_if;
  logic scl_o_m;
  logic scl_oe_m;
  logic sda_o_m;
  logic sda_oe_m;
  logic sda_o_d;
  logic sda_oe_d;
  logic scl;
  logic sda;
  // Open-drain wires: released line reads high
  assign scl = scl_oe_m ? scl_o_m : 1'b1;
  assign sda = (sda_oe_m ? sda_o_m : 1'b1) & (sda_oe_d ? sda_o_d : 1'b1);
  modport device (input scl, input sda, output sda_o_d, output sda_oe_d);
  modport controller (output scl_o_m, output scl_oe_m, output sda_o_m, output sda_oe_m, input sda);
endinterface

/* rtl/qdw_device.sv */
`timescale 1ns/1ns
// Function
// - Master opens with start, write address, control
// - Address 10011, pin bits, write bit
// - Control byte picks mode and channel
// - Control: zeros, load, spare, channel, kind
// - Kind bit selects power-down or data
// - Data pairs repeat until stop or restart
// - High byte D11-D4, low nibble ignored
// - Power-down mode takes exactly two bytes
// - Power-down bytes: mode bits then zeros
// - Acknowledge address, control and data bytes
// - Master ends power-down with stop or restart
// - Master sends high-speed entry code first
// - Never acknowledge the high-speed entry code
// - High speed uses the same byte formats
// - Master sends control before data bytes
// - Update at end of low-byte acknowledge
// - Fourteen-bit holding and output per channel
// - Load field selects which registers update
module qdw_device (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic [1:0] I_ADDR_PINS,
  output logic [qdw_pkg::CH_N*qdw_pkg::WORD_W-1:0] O_CHANNEL_HOLDING_REG,
  output logic [qdw_pkg::CH_N*qdw_pkg::WORD_W-1:0] O_CHANNEL_OUTPUT_REG,
  qdw_if.device BUS
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic [1:0] pins_m;
    logic [1:0] pins_s;
    qdw_pkg::qdw_dstate_type st;
    logic [3:0] cnt;
    logic in_ack;
    logic ack_oe;
    logic apply;
    logic [7:0] sr;
    logic [7:0] ctrl;
    logic [7:0] hi;
    logic [qdw_pkg::PD_W-1:0] pd;
    logic [qdw_pkg::CH_N-1:0][qdw_pkg::WORD_W-1:0] hold;
    logic [qdw_pkg::CH_N-1:0][qdw_pkg::WORD_W-1:0] outr;
  } qdw_dev_state_type;

  qdw_dev_state_type s;
  qdw_dev_state_type next_s;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic addr_match;
  logic [1:0] load;
  logic [qdw_pkg::CH_W-1:0] chan;
  logic kind;
  logic [qdw_pkg::DATA_W-1:0] data_word;

  // ----------------------------------------
  // Line events
  // ----------------------------------------
  // Only second- and third-stage copies feed detectors; first stage stays private
  assign scl_rise = s.scl_s & ~s.scl_d;
  assign scl_fall = ~s.scl_s & s.scl_d;
  assign start_cond = s.scl_s & s.scl_d & s.sda_d & ~s.sda_s;
  assign stop_cond = s.scl_s & s.scl_d & ~s.sda_d & s.sda_s;

  // Byte field decode
  assign addr_match = (s.sr[7:qdw_pkg::ADDR_FIXED_LSB] == qdw_pkg::ADDR_FIXED) &&
                      (s.sr[qdw_pkg::ADDR_PIN_LSB +: 2] == s.pins_s) &&
                      (s.sr[qdw_pkg::ADDR_RW_BIT] == qdw_pkg::ADDR_RW_WRITE);
  assign load = s.ctrl[qdw_pkg::CTRL_LOAD_LSB +: 2];
  assign chan = s.ctrl[qdw_pkg::CTRL_CHAN_LSB +: qdw_pkg::CH_W];
  assign kind = s.ctrl[qdw_pkg::CTRL_KIND_BIT];
  assign data_word = {s.hi, s.sr[7 -: qdw_pkg::NIB_W]};

  // ----------------------------------------
  // Receiver next state
  // ----------------------------------------
  always_comb begin
    logic [qdw_pkg::WORD_W-1:0] w;
    logic sel;
    w = '0;
    sel = 1'b0;
    next_s = s;
    next_s.scl_m = BUS.scl;
    next_s.scl_s = s.scl_m;
    next_s.scl_d = s.scl_s;
    next_s.sda_m = BUS.sda;
    next_s.sda_s = s.sda_m;
    next_s.sda_d = s.sda_s;
    next_s.pins_m = I_ADDR_PINS;
    next_s.pins_s = s.pins_m;
    if (start_cond) begin
      // Start or restart aborts anything half done
      next_s.st = qdw_pkg::D_ADDR;
      next_s.cnt = '0;
      next_s.in_ack = 1'b0;
      next_s.ack_oe = 1'b0;
      next_s.apply = 1'b0;
    end else if (stop_cond) begin
      next_s.st = qdw_pkg::D_IDLE;
      next_s.cnt = '0;
      next_s.in_ack = 1'b0;
      next_s.ack_oe = 1'b0;
      next_s.apply = 1'b0;
    end else if (scl_rise && s.cnt < qdw_pkg::ACK_IDX) begin
      next_s.sr = {s.sr[6:0], s.sda_s};
      next_s.cnt = s.cnt + 4'h1;
    end else if (scl_fall && s.cnt == qdw_pkg::ACK_IDX && !s.in_ack) begin
      // Eighth bit done: decide on acknowledge
      next_s.in_ack = 1'b1;
      case (s.st)
        qdw_pkg::D_ADDR: begin
          if (addr_match) begin
            next_s.ack_oe = 1'b1;
            next_s.st = qdw_pkg::D_CTRL;
          end else begin
            // Entry code and foreign addresses fall here, line stays free
            next_s.st = qdw_pkg::D_SKIP;
          end
        end
        qdw_pkg::D_CTRL: begin
          next_s.ack_oe = 1'b1;
          next_s.ctrl = s.sr;
          if (s.sr[qdw_pkg::CTRL_LOAD_LSB +: 2] == qdw_pkg::LOAD_BCAST && !s.sr[qdw_pkg::CTRL_BCAST_BIT]) begin
            next_s.apply = 1'b1;
            next_s.st = qdw_pkg::D_DONE;
          end else if (s.sr[qdw_pkg::CTRL_KIND_BIT]) begin
            next_s.st = qdw_pkg::D_PD1;
          end else begin
            next_s.st = qdw_pkg::D_HI;
          end
        end
        qdw_pkg::D_HI: begin
          next_s.ack_oe = 1'b1;
          next_s.hi = s.sr;
          next_s.st = qdw_pkg::D_LO;
        end
        qdw_pkg::D_LO: begin
          next_s.ack_oe = 1'b1;
          next_s.apply = 1'b1;
          next_s.st = qdw_pkg::D_HI;
        end
        qdw_pkg::D_PD1: begin
          next_s.ack_oe = 1'b1;
          next_s.pd = s.sr[qdw_pkg::PD_LSB +: qdw_pkg::PD_W];
          next_s.st = qdw_pkg::D_PD2;
        end
        qdw_pkg::D_PD2: begin
          next_s.ack_oe = 1'b1;
          next_s.apply = 1'b1;
          next_s.st = qdw_pkg::D_DONE;
        end
        default: begin
          next_s.ack_oe = 1'b0;
        end
      endcase
    end else if (scl_fall && s.in_ack) begin
      // Acknowledge clock ends: release line and commit
      next_s.in_ack = 1'b0;
      next_s.ack_oe = 1'b0;
      next_s.cnt = '0;
      next_s.apply = 1'b0;
      if (s.apply) begin
        for (int i = 0; i < qdw_pkg::CH_N; i++) begin
          sel = (chan == qdw_pkg::CH_W'(i));
          // Power-down keeps the stored data bits of the channel
          w = kind ? {s.pd, s.hold[i][qdw_pkg::DATA_W-1:0]} : {{qdw_pkg::PD_W{1'b0}}, data_word};
          case (load)
            qdw_pkg::LOAD_HOLD: begin
              if (sel) next_s.hold[i] = w;
            end
            qdw_pkg::LOAD_ONE: begin
              if (sel) begin
                next_s.hold[i] = w;
                next_s.outr[i] = w;
              end
            end
            qdw_pkg::LOAD_ALL: begin
              next_s.hold[i] = sel ? w : s.hold[i];
              next_s.outr[i] = sel ? w : s.hold[i];
            end
            default: begin
              if (s.ctrl[qdw_pkg::CTRL_BCAST_BIT]) begin
                next_s.hold[i] = w;
                next_s.outr[i] = w;
              end else begin
                next_s.outr[i] = s.hold[i];
              end
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Power-on state: all channels zero, receiver idle
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s <= '0;
      s.scl_m <= 1'b1;
      s.scl_s <= 1'b1;
      s.scl_d <= 1'b1;
      s.sda_m <= 1'b1;
      s.sda_s <= 1'b1;
      s.sda_d <= 1'b1;
      s.st <= qdw_pkg::D_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // Outputs; the device only ever pulls data low
  assign BUS.sda_o_d = 1'b0;
  assign BUS.sda_oe_d = s.ack_oe;
  assign O_CHANNEL_HOLDING_REG = s.hold;
  assign O_CHANNEL_OUTPUT_REG = s.outr;

endmodule

/* rtl/qdw_controller.sv */
`timescale 1ns/1ns
module qdw_controller (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic [qdw_pkg::AXI_AW-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [qdw_pkg::AXI_AW-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  qdw_if.controller BUS
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    qdw_pkg::qdw_mstate_type st;
    logic [1:0] q;
    logic [7:0] div;
    logic [3:0] bit_idx;
    logic [2:0] byte_idx;
    logic [31:0] cmd;
    logic busy;
    logic nack;
    logic ack;
    logic hs_speed;
    logic scl_oe;
    logic sda_oe;
    logic sda_m;
    logic sda_s;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } qdw_ctl_state_type;

  qdw_ctl_state_type s;
  qdw_ctl_state_type next_s;
  logic wtake;
  logic rtake;
  logic [7:0] cur;
  logic [2:0] last_idx;
  logic [1:0] c_load;
  logic [1:0] c_chan;
  logic c_kind;

  // Address and data are taken together, one write in flight
  assign wtake = I_AWVALID & I_WVALID & ~s.bvalid;
  assign rtake = I_ARVALID & ~s.rvalid;
  assign c_load = s.cmd[qdw_pkg::CMD_LOAD_LSB +: 2];
  assign c_chan = s.cmd[qdw_pkg::CMD_CHAN_LSB +: 2];
  assign c_kind = s.cmd[qdw_pkg::CMD_KIND_BIT];
  // Stored-data broadcast carries no data bytes
  assign last_idx = (c_load == qdw_pkg::LOAD_BCAST && !c_chan[1]) ? qdw_pkg::IDX_CTRL : qdw_pkg::IDX_LO;

  // ----------------------------------------
  // Byte builder
  // ----------------------------------------
  always_comb begin
    case (s.byte_idx)
      3'h0: cur = qdw_pkg::HS_CODE;
      3'h1: cur = {qdw_pkg::ADDR_FIXED, s.cmd[qdw_pkg::CMD_PIN_LSB +: 2], qdw_pkg::ADDR_RW_WRITE};
      3'h2: cur = {2'h0, c_load, 1'h0, c_chan, c_kind};
      3'h3: cur = c_kind ? {s.cmd[qdw_pkg::CMD_PD_LSB +: 2], 6'h00} :
                  s.cmd[qdw_pkg::CMD_DATA_LSB + qdw_pkg::LO_DATA_LSB +: 8];
      default: cur = c_kind ? 8'h00 : {s.cmd[qdw_pkg::CMD_DATA_LSB +: 4], 4'h0};
    endcase
  end

  // ----------------------------------------
  // Sequencer and register slave
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.sda_m = BUS.sda;
    next_s.sda_s = s.sda_m;
    // Register bus: write response, then read response
    if (s.bvalid && I_BREADY) next_s.bvalid = 1'b0;
    if (s.rvalid && I_RREADY) next_s.rvalid = 1'b0;
    if (wtake) begin
      next_s.bvalid = 1'b1;
      next_s.bresp = (I_AWADDR == qdw_pkg::REG_CMD || I_AWADDR == qdw_pkg::REG_STAT) ?
                     qdw_pkg::RESP_OKAY : qdw_pkg::RESP_SLVERR;
    end
    if (rtake) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = qdw_pkg::RESP_OKAY;
      if (I_ARADDR == qdw_pkg::REG_CMD) begin
        next_s.rdata = s.cmd;
      end else if (I_ARADDR == qdw_pkg::REG_STAT) begin
        next_s.rdata = {30'h0, s.nack, s.busy};
      end else begin
        next_s.rdata = 32'h0;
        next_s.rresp = qdw_pkg::RESP_SLVERR;
      end
    end
    if (s.st == qdw_pkg::M_IDLE) begin
      // Command write while busy is ignored
      if (wtake && I_AWADDR == qdw_pkg::REG_CMD) begin
        for (int b = 0; b < 4; b++) begin
          if (I_WSTRB[b]) next_s.cmd[b*8 +: 8] = I_WDATA[b*8 +: 8];
        end
        next_s.st = qdw_pkg::M_START;
        next_s.busy = 1'b1;
        next_s.nack = 1'b0;
        next_s.hs_speed = 1'b0;
        next_s.q = 2'h0;
        next_s.div = qdw_pkg::FS_QTR_CYC - 8'h1;
        next_s.byte_idx = next_s.cmd[qdw_pkg::CMD_HS_BIT] ? qdw_pkg::IDX_HS : qdw_pkg::IDX_ADDR;
      end
    end else if (s.div != 8'h0) begin
      next_s.div = s.div - 8'h1;
    end else begin
      // Quarter-bit tick; high speed only after the entry code
      next_s.div = (s.hs_speed ? qdw_pkg::HS_QTR_CYC : qdw_pkg::FS_QTR_CYC) - 8'h1;
      next_s.q = s.q + 2'h1;
      case (s.st)
        qdw_pkg::M_START: begin
          // Clock low, data free, clock high, data low, clock low
          case (s.q)
            2'h0: begin
              next_s.scl_oe = 1'b1;
              next_s.sda_oe = 1'b0;
            end
            2'h1: next_s.scl_oe = 1'b0;
            2'h2: next_s.sda_oe = 1'b1;
            default: begin
              next_s.scl_oe = 1'b1;
              next_s.st = qdw_pkg::M_BIT;
              next_s.bit_idx = 4'h0;
            end
          endcase
        end
        qdw_pkg::M_BIT: begin
          case (s.q)
            2'h0: next_s.sda_oe = (s.bit_idx == qdw_pkg::ACK_IDX) ? 1'b0 : ~cur[3'(7 - s.bit_idx)];
            2'h1: next_s.scl_oe = 1'b0;
            2'h2: next_s.ack = ~s.sda_s;
            default: begin
              next_s.scl_oe = 1'b1;
              if (s.bit_idx != qdw_pkg::ACK_IDX) begin
                next_s.bit_idx = s.bit_idx + 4'h1;
              end else if (s.byte_idx == qdw_pkg::IDX_HS) begin
                // Entry code is never acknowledged; restart at high speed
                next_s.hs_speed = 1'b1;
                next_s.byte_idx = qdw_pkg::IDX_ADDR;
                next_s.st = qdw_pkg::M_START;
              end else if (!s.ack) begin
                next_s.nack = 1'b1;
                next_s.st = qdw_pkg::M_STOP;
              end else if (s.byte_idx == last_idx) begin
                next_s.st = qdw_pkg::M_STOP;
              end else begin
                next_s.byte_idx = s.byte_idx + 3'h1;
                next_s.bit_idx = 4'h0;
              end
            end
          endcase
        end
        default: begin
          // Data low, clock high, data released
          case (s.q)
            2'h0: next_s.sda_oe = 1'b1;
            2'h1: next_s.scl_oe = 1'b0;
            2'h2: next_s.sda_oe = 1'b0;
            default: begin
              next_s.st = qdw_pkg::M_IDLE;
              next_s.busy = 1'b0;
              next_s.hs_speed = 1'b0;
            end
          endcase
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s <= '0;
      s.sda_m <= 1'b1;
      s.sda_s <= 1'b1;
      s.st <= qdw_pkg::M_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // Outputs
  assign O_AWREADY = wtake;
  assign O_WREADY = wtake;
  assign O_BVALID = s.bvalid;
  assign O_BRESP = s.bresp;
  assign O_ARREADY = ~s.rvalid;
  assign O_RVALID = s.rvalid;
  assign O_RDATA = s.rdata;
  assign O_RRESP = s.rresp;
  assign BUS.scl_o_m = 1'b0;
  assign BUS.scl_oe_m = s.scl_oe;
  assign BUS.sda_o_m = 1'b0;
  assign BUS.sda_oe_m = s.sda_oe;

endmodule

/* sim/qdw_props.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Serial link checker
// ----------------------------------------
module qdw_props (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic scl_o_m,
  input wire logic scl_oe_m,
  input wire logic sda_o_m,
  input wire logic sda_oe_m,
  input wire logic sda_o_d,
  input wire logic sda_oe_d,
  input wire logic scl,
  input wire logic sda
);
  logic [3:0] cnt;
  logic [7:0] sh;
  logic [1:0] nbyte;
  logic addr_ok;
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  // Byte tracker; a start realigns it so restarts line up
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cnt <= 4'h0;
      sh <= 8'h00;
      nbyte <= 2'h0;
      addr_ok <= 1'b0;
    end else if (scl && $fell(sda)) begin
      cnt <= 4'h0;
      nbyte <= 2'h0;
      addr_ok <= 1'b0;
    end else if ($rose(scl)) begin
      if (cnt == 4'h8) begin
        cnt <= 4'h0;
        nbyte <= (nbyte == 2'h3) ? nbyte : nbyte + 2'h1;
        if (nbyte == 2'h0) begin
          addr_ok <= sda_oe_d;
        end
      end else begin
        cnt <= cnt + 4'h1;
        sh <= {sh[6:0], sda};
      end
    end
  end
  // Ninth clock of a byte: the acknowledge slot
  sequence s_ninth;
    $rose(scl) && cnt == 4'h8;
  endsequence
  property p_ninth(logic c, logic w);
    s_ninth ##0 c |-> sda_oe_d == w;
  endproperty
  a_open_drain: assert property (!scl_o_m && !sda_o_m && !sda_o_d)
    else $error("line driven high");
  a_ack_on_low: assert property ($rose(sda_oe_d) |-> !scl)
    else $error("ack raised with clock high");
  a_ack_off_low: assert property ($fell(sda_oe_d) |-> !scl)
    else $error("ack dropped with clock high");
  a_ack_ninth: assert property ($rose(scl) && cnt != 4'h8 |-> !sda_oe_d)
    else $error("data line pulled outside ack slot");
  a_no_code_ack: assert property (p_ninth(nbyte == 2'h0 && sh == qdw_pkg::HS_CODE, 1'b0))
    else $error("entry code acknowledged");
  a_foreign_nack: assert property (p_ninth(nbyte == 2'h0 && (sh[7:3] != qdw_pkg::ADDR_FIXED || sh[0]), 1'b0))
    else $error("foreign address acknowledged");
  a_ctrl_ack: assert property (p_ninth(nbyte == 2'h1 && addr_ok, 1'b1))
    else $error("control byte not acknowledged");
  a_ack_release: assert property ($fell(scl) && cnt == 4'h0 && sda_oe_d |-> ##[1:8] !sda_oe_d)
    else $error("ack held past its slot");
endmodule

/* sim/tb.sv */
`timescale 1ns/1ns
module tb;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] pins, bresp, rresp, rsp;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata, seed, d;
  logic [55:0] hold1, out1, hold2, out2, exp_h, exp_o;
  logic [7:0] adr;
  int n_fail, checked, cyc;
  qdw_if bus();
  qdw_if b2();
  qdw_controller qdw_controller_inst (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hf), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
    .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .BUS(bus));
  qdw_device qdw_device_inst (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_ADDR_PINS(pins),
    .O_CHANNEL_HOLDING_REG(hold1), .O_CHANNEL_OUTPUT_REG(out1), .BUS(bus));
  // Second device faces a bit-banged master that breaks sequences on purpose
  qdw_device qdw_device_inst2 (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_ADDR_PINS(pins),
    .O_CHANNEL_HOLDING_REG(hold2), .O_CHANNEL_OUTPUT_REG(out2), .BUS(b2));
  qdw_props qdw_props_inst (.I_CORE_CLK(clk), .I_RST_N(rst_n), .scl_o_m(bus.scl_o_m), .scl_oe_m(bus.scl_oe_m),
    .sda_o_m(bus.sda_o_m), .sda_oe_m(bus.sda_oe_m), .sda_o_d(bus.sda_o_d), .sda_oe_d(bus.sda_oe_d),
    .scl(bus.scl), .sda(bus.sda));
  // ----------------------------------------
  // Checking and verdict
  // ----------------------------------------
  task automatic chk(input logic [55:0] seen, input logic [55:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (n_fail == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected register state after one accepted word; broadcast with channel bit 1 set writes every channel
  function automatic void apply(input logic [1:0] ld, input logic [1:0] ch, input logic kind,
    input logic [1:0] pd, input logic [11:0] dt);
    for (int c = 0; c < 4; c++) begin
      if ((ld == qdw_pkg::LOAD_BCAST) ? ch[1] : (c == int'(ch))) begin
        exp_h[c*14 +: 14] = kind ? {pd, exp_h[c*14 +: 12]} : {2'h0, dt};
      end
    end
    if (ld == qdw_pkg::LOAD_ONE) exp_o[int'(ch)*14 +: 14] = exp_h[int'(ch)*14 +: 14];
    if (ld == qdw_pkg::LOAD_ALL || ld == qdw_pkg::LOAD_BCAST) exp_o = exp_h;
  endfunction
  // ----------------------------------------
  // Register bus master
  // ----------------------------------------
  task automatic axw(input logic [3:0] a, input logic [31:0] v, input logic [1:0] r);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(negedge clk); while (awready !== 1'b1);
    @(posedge clk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(negedge clk); while (bvalid !== 1'b1);
    chk(bresp, r);
    @(posedge clk);
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] v, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    @(posedge clk);
    rready <= 1'b0;
    @(posedge clk);
  endtask
  // One transfer; i picks speed, load field and data kind from a small table
  task automatic xfer(input int i, input logic [31:0] s, input logic [1:0] p);
    logic [1:0] ld, ch, r;
    logic kind;
    logic [31:0] cmd;
    ld = 2'(10'h1c9 >> (2 * i));
    kind = (i == 2) || (i == 3);
    ch = {s[17] & (i != 4), s[16]};
    cmd = {2'h0, p, 2'h0, i != 0, kind, 2'h0, ld, 2'h0, ch, 2'h0, s[13:0]};
    axw(qdw_pkg::REG_CMD, cmd, qdw_pkg::RESP_OKAY);
    if (i == 0) axw(qdw_pkg::REG_CMD, ~cmd, qdw_pkg::RESP_OKAY);
    do axr(qdw_pkg::REG_STAT, d, r); while (d[0] === 1'b1);
    if (p == pins) apply(ld, ch, kind, s[13:12], s[11:0]);
    chk(d[1], p != pins);
    axr(qdw_pkg::REG_CMD, d, r);
    chk(d, cmd);
    chk(hold1, exp_h);
    chk(out1, exp_o);
  endtask
  // ----------------------------------------
  // Bit-banged master, one 80 ns clock per bit
  // ----------------------------------------
  task automatic bitx(input logic v);
    b2.scl_oe_m <= 1'b1;
    repeat (5) @(posedge clk);
    b2.sda_oe_m <= !v;
    repeat (5) @(posedge clk);
    b2.scl_oe_m <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
  // Data set opposite to the wanted edge, then flipped while the clock is high
  task automatic cnd(input logic stop);
    bitx(!stop);
    b2.sda_oe_m <= !stop;
    repeat (10) @(posedge clk);
  endtask
  task automatic bbyte(input logic [7:0] b, input logic a);
    for (int k = 7; k >= 0; k--) bitx(b[k]);
    bitx(1'b1);
    chk(b2.sda, !a);
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 100000) begin
      n_fail++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    {b2.scl_o_m, b2.sda_o_m, b2.scl_oe_m, b2.sda_oe_m} = 4'h0;
    {n_fail, checked, cyc} = '0;
    {exp_h, exp_o} = '0;
    pins = 2'h2;
    seed = 32'h00015d56;
    adr = {qdw_pkg::ADDR_FIXED, 2'h2, 1'b0};
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(hold1, '0);
    chk(out1, '0);
    axw(4'h8, 32'h0, qdw_pkg::RESP_SLVERR);
    axw(qdw_pkg::REG_STAT, 32'hffffffff, qdw_pkg::RESP_OKAY);
    axr(4'hc, d, rsp);
    chk({d, rsp}, {32'h0, qdw_pkg::RESP_SLVERR});
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      xfer(i, seed, pins);
    end
    xfer(1, lfsr(seed), pins ^ 2'h1);
    cnd(1'b0);
    bbyte(adr, 1'b1);
    bbyte(8'h10, 1'b1);
    bbyte(8'hab, 1'b1);
    cnd(1'b0);
    chk(hold2, '0);
    chk(out2, '0);
    bbyte(qdw_pkg::HS_CODE, 1'b0);
    cnd(1'b0);
    bbyte(adr ^ 8'h08, 1'b0);
    cnd(1'b0);
    bbyte(adr, 1'b1);
    bbyte(8'h16, 1'b1);
    bbyte(8'ha5, 1'b1);
    bbyte(8'h3c, 1'b1);
    bbyte(8'h5a, 1'b1);
    chk(hold2[55:42], 14'h0a53);
    bbyte(8'hcf, 1'b1);
    cnd(1'b1);
    chk(out2, {14'h05ac, 42'h0});
    print_verdict();
  end
endmodule
